// [common/sfw_pkg.sv]
// Constants and types for the serial flash wipe and sleep sequencer.
// Operation
// - Block wipe sets all bits of the addressed sector to one.
// - Wipes are accepted only while the write permit latch is set.
// - Block wipe is opcode plus three address bytes; top two address bits ignored.
// - Block wipe executes only when select rises right after the last address byte.
// - Block wipe runs self-timed, busy flag high meanwhile, permit latch cleared early.
// - Block wipe of a protected sector is not executed.
// - Whole array wipe is opcode alone and sets the whole array to one.
// - Whole array wipe executes only when select rises right after eight bits.
// - Whole array wipe runs self-timed with busy high and permit latch cleared early.
// - Whole array wipe executes only when all protect level bits are zero.
// - Sleep entry is opcode alone on a byte edge; sleep begins after its delay.
// - In deep sleep every instruction except sleep exit is ignored.
// - Raising select with no cycle running means standby, not deep sleep.
// - Sleep exit is opcode then select rise; extra clock edges reject it.
// - After a valid sleep exit the device reaches standby after the exit delay.
// - Sleep entry or exit during a running cycle is rejected, cycle untouched.
// - Power-on reset holds all logic reset and answers no instruction.
// - Write type instructions are ignored until the write inhibit delay elapses.
// - Read instructions are accepted before the write inhibit delay expires.
// - After reset: standby, permit latch and busy clear, sector lock bits zero.
package sfw_pkg;

  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_UNLOCK    = 8'h10;
  localparam logic [7:0] OP_BLOCK_WIPE      = 8'h20;
  localparam logic [7:0] OP_WHOLE_WIPE      = 8'h30;
  localparam logic [7:0] OP_SLEEP_ENTRY     = 8'h40;
  localparam logic [7:0] OP_SLEEP_EXIT      = 8'h50;
  localparam logic [7:0] OP_PAGE_WRITE      = 8'h60;
  localparam logic [7:0] OP_TWO_LINE_WRITE  = 8'h61;
  localparam logic [7:0] OP_ONE_TIME_WRITE  = 8'h62;
  localparam logic [7:0] OP_SMALL_WIPE      = 8'h63;
  localparam logic [7:0] OP_STATUS_WRITE    = 8'h64;
  localparam logic [7:0] OP_LOCK_WRITE      = 8'h65;

  // ----------------------------------------------------------------
  // Framing and field positions
  // ----------------------------------------------------------------
  localparam logic [5:0] BITS_OPCODE        = 6'h08;
  localparam logic [5:0] BITS_ADDR_FRAME    = 6'h20;
  localparam logic [5:0] BITS_SATURATE      = 6'h3f;
  localparam int         SECTOR_LSB         = 16;
  localparam int         SECTOR_MSB         = 21;
  localparam logic [5:0] SECTOR_COUNT_M1    = 6'h3f;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ                    = 100;
  localparam int WRITE_INHIBIT_MS           = 1;
  localparam int WRITE_INHIBIT_CYCLES       = WRITE_INHIBIT_MS * 1000 * 1000 * CLK_MHZ / 1000;
  localparam int BLOCK_WIPE_CYCLES          = 5000;
  localparam int ARRAY_WIPE_CYCLES          = 20000;
  localparam int SLEEP_ENTRY_CYCLES         = 300;
  localparam int SLEEP_EXIT_CYCLES          = 300;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] TIMER_RESET       = 32'h0000_0000;
  localparam logic [2:0]  SYNC_RESET        = 3'h7;

  typedef enum logic [2:0] {
    SFW_STANDBY     = 3'b000,
    SFW_WIPING      = 3'b100,
    SFW_SLEEP_ENTER = 3'b001,
    SFW_SLEEP       = 3'b011,
    SFW_SLEEP_EXIT  = 3'b010
  } sfw_state_t;

endpackage

// [hw/sfw_sequencer.sv]
// Serial flash wipe, deep sleep and power-up write inhibit sequencer.
`timescale 1ns/1ps
module sfw_sequencer #(
  parameter int WRITE_INHIBIT_CYC = sfw_pkg::WRITE_INHIBIT_CYCLES,
  parameter int BLOCK_WIPE_CYC    = sfw_pkg::BLOCK_WIPE_CYCLES,
  parameter int ARRAY_WIPE_CYC    = sfw_pkg::ARRAY_WIPE_CYCLES,
  parameter int SLEEP_ENTRY_CYC   = sfw_pkg::SLEEP_ENTRY_CYCLES,
  parameter int SLEEP_EXIT_CYC    = sfw_pkg::SLEEP_EXIT_CYCLES
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       spi_clk,
  input  wire logic       spi_cs_n,
  input  wire logic       serial_in_line,
  input  wire logic [2:0] protect_level_bits,
  output logic            cycle_in_progress,
  output logic            write_permit_latch,
  output logic            deep_sleep,
  output logic            standby,
  output logic            write_inhibit,
  output logic            wipe_start,
  output logic            wipe_all,
  output logic [5:0]      wipe_sector,
  output logic            wipe_done,
  output logic            lock_bits_clear
);
  import sfw_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // The link clock is slow against core_clk, so three flops with a second and
  // third agreement filter are enough to reject single-cycle glitches.
  localparam logic [2:0] PIN_IDLE = {1'b0, SYNC_RESET[0], 1'b0};

  logic [2:0] pin_raw;
  logic [2:0] pin_sync_q [3];
  logic       pin_agree  [3];
  logic       pin_flt_q  [3];
  logic [2:0] sclk_s_q;
  logic [2:0] cs_s_q;
  logic       sclk_f_q;
  logic       cs_f_q;
  logic       din_f_q;

  // Order is serial clock, select, data; select idles high.
  assign pin_raw = {serial_in_line, spi_cs_n, spi_clk};

  for (genvar i = 0; i < 3; i++) begin : g_pin
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        pin_sync_q[i] <= {3{PIN_IDLE[i]}};
      end else if (clk_en) begin
        pin_sync_q[i] <= {pin_sync_q[i][1:0], pin_raw[i]};
      end
    end

    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        pin_flt_q[i] <= PIN_IDLE[i];
      end else if (clk_en && pin_agree[i]) begin
        pin_flt_q[i] <= pin_sync_q[i][2];
      end
    end

    assign pin_agree[i] = (pin_sync_q[i][1] == pin_sync_q[i][2]);
  end

  assign sclk_s_q = pin_sync_q[0];
  assign cs_s_q   = pin_sync_q[1];
  assign sclk_f_q = pin_flt_q[0];
  assign cs_f_q   = pin_flt_q[1];
  assign din_f_q  = pin_flt_q[2];

  logic sclk_rise;
  logic cs_rise;
  assign sclk_rise = (sclk_s_q[1] == sclk_s_q[2]) && sclk_s_q[2] && !sclk_f_q && !cs_f_q;
  assign cs_rise   = (cs_s_q[1] == cs_s_q[2]) && cs_s_q[2] && !cs_f_q;

  // ----------------------------------------------------------------
  // Serial shifter
  // ----------------------------------------------------------------
  logic [31:0] shift_q;
  logic [5:0]  bits_q;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      shift_q <= 32'h0000_0000;
      bits_q  <= 6'h00;
    end else if (clk_en) begin
      if (cs_f_q) begin
        bits_q <= 6'h00;
      end else if (sclk_rise) begin
        shift_q <= {shift_q[30:0], din_f_q};
        if (bits_q != BITS_SATURATE) begin
          bits_q <= bits_q + 6'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Decode at select release
  // ----------------------------------------------------------------
  function automatic logic sector_protected(input logic [2:0] level, input logic [5:0] sector);
    logic [6:0] span;
    span = 7'h00;
    if (level != 3'h0) begin
      span = 7'h01 << (level - 3'h1);
    end
    sector_protected = ({1'b0, sector} > ({1'b0, SECTOR_COUNT_M1} - span));
  endfunction

  function automatic logic is_write_type(input logic [7:0] op);
    is_write_type = (op == OP_WRITE_UNLOCK) || (op == OP_PAGE_WRITE) || (op == OP_TWO_LINE_WRITE) ||
                    (op == OP_ONE_TIME_WRITE) || (op == OP_SMALL_WIPE) || (op == OP_BLOCK_WIPE) ||
                    (op == OP_WHOLE_WIPE) || (op == OP_STATUS_WRITE) || (op == OP_LOCK_WRITE);
  endfunction

  sfw_state_t  state_q;
  logic [31:0] timer_q;
  logic [31:0] inhibit_q;

  logic [7:0] op8;
  logic [7:0] op32;
  logic [5:0] sector;
  logic       byte8;
  logic       frame32;
  logic       idle;
  logic       go_unlock;
  logic       go_block;
  logic       go_whole;
  logic       go_enter;
  logic       go_exit;

  assign op8     = shift_q[7:0];
  assign op32    = shift_q[31:24];
  assign sector  = shift_q[SECTOR_MSB:SECTOR_LSB];
  assign byte8   = cs_rise && (bits_q == BITS_OPCODE);
  assign frame32 = cs_rise && (bits_q == BITS_ADDR_FRAME);
  assign idle    = (state_q == SFW_STANDBY) && !inhibit_q[31];
  assign go_unlock = idle && byte8 && (op8 == OP_WRITE_UNLOCK) && !write_inhibit;
  assign go_block  = idle && frame32 && (op32 == OP_BLOCK_WIPE) && write_permit_latch &&
                     !write_inhibit && !sector_protected(protect_level_bits, sector);
  assign go_whole  = idle && byte8 && (op8 == OP_WHOLE_WIPE) && write_permit_latch &&
                     !write_inhibit && (protect_level_bits == 3'h0);
  assign go_enter  = idle && byte8 && (op8 == OP_SLEEP_ENTRY);
  assign go_exit   = (state_q == SFW_SLEEP) && byte8 && (op8 == OP_SLEEP_EXIT);

  // ----------------------------------------------------------------
  // Power-up write inhibit
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      inhibit_q     <= TIMER_RESET;
      write_inhibit <= 1'b1;
    end else if (clk_en) begin
      if (inhibit_q < 32'(WRITE_INHIBIT_CYC)) begin
        inhibit_q <= inhibit_q + 32'h1;
      end
      write_inhibit <= (inhibit_q < 32'(WRITE_INHIBIT_CYC) - 32'h1);
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= SFW_STANDBY;
      timer_q <= TIMER_RESET;
    end else if (clk_en) begin
      case (state_q)
        SFW_STANDBY: begin
          if (go_block) begin
            state_q <= SFW_WIPING;
            timer_q <= 32'(BLOCK_WIPE_CYC) - 32'h1;
          end else if (go_whole) begin
            state_q <= SFW_WIPING;
            timer_q <= 32'(ARRAY_WIPE_CYC) - 32'h1;
          end else if (go_enter) begin
            state_q <= SFW_SLEEP_ENTER;
            timer_q <= 32'(SLEEP_ENTRY_CYC) - 32'h1;
          end
        end
        SFW_WIPING: begin
          if (timer_q == 32'h0) begin
            state_q <= SFW_STANDBY;
          end else begin
            timer_q <= timer_q - 32'h1;
          end
        end
        SFW_SLEEP_ENTER: begin
          if (timer_q == 32'h0) begin
            state_q <= SFW_SLEEP;
          end else begin
            timer_q <= timer_q - 32'h1;
          end
        end
        SFW_SLEEP: begin
          if (go_exit) begin
            state_q <= SFW_SLEEP_EXIT;
            timer_q <= 32'(SLEEP_EXIT_CYC) - 32'h1;
          end
        end
        SFW_SLEEP_EXIT: begin
          if (timer_q == 32'h0) begin
            state_q <= SFW_STANDBY;
          end else begin
            timer_q <= timer_q - 32'h1;
          end
        end
        default: begin
          state_q <= SFW_STANDBY;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Status and array controls
  // ----------------------------------------------------------------
  logic wipe_end;
  assign wipe_end = (state_q == SFW_WIPING) && (timer_q == 32'h0);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      write_permit_latch <= 1'b0;
    end else if (clk_en) begin
      if (go_unlock) begin
        write_permit_latch <= 1'b1;
      end else if (go_block || go_whole) begin
        write_permit_latch <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cycle_in_progress <= 1'b0;
    end else if (clk_en) begin
      if (go_block || go_whole) begin
        cycle_in_progress <= 1'b1;
      end else if (wipe_end) begin
        cycle_in_progress <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wipe_start <= 1'b0;
      wipe_done  <= 1'b0;
    end else if (clk_en) begin
      wipe_start <= go_block || go_whole;
      wipe_done  <= wipe_end;
    end
  end

  // Target fields hold until the next accepted wipe, so the array side may
  // read them at any point of the running cycle.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wipe_all    <= 1'b0;
      wipe_sector <= 6'h00;
    end else if (clk_en) begin
      if (go_block) begin
        wipe_all    <= 1'b0;
        wipe_sector <= sector;
      end else if (go_whole) begin
        wipe_all    <= 1'b1;
        wipe_sector <= 6'h00;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      deep_sleep <= 1'b0;
    end else if (clk_en) begin
      deep_sleep <= (state_q == SFW_SLEEP) || (state_q == SFW_SLEEP_EXIT);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      standby <= 1'b0;
    end else if (clk_en) begin
      standby <= (state_q == SFW_STANDBY) && cs_f_q;
    end
  end

  // The clear stands through reset and one cycle beyond, so the lock
  // registers outside always see at least one clean clear.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lock_bits_clear <= 1'b1;
    end else if (clk_en) begin
      lock_bits_clear <= 1'b0;
    end
  end

endmodule

// [verification/sfw_host_model.sv]
// Behavioural host controller that frames serial instructions for the sequencer.
`timescale 1ns/1ps
module sfw_host_model (
  output logic spi_clk,
  output logic spi_cs_n,
  output logic serial_in_line
);
  // The serial clock idles low and stands still between frames.
  initial begin
    spi_clk        = 1'b0;
    spi_cs_n       = 1'b1;
    serial_in_line = 1'b0;
  end
  // Extra bits beyond the frame break the byte boundary on purpose.
  task automatic frame(input logic [7:0] op, input logic ad, input logic [23:0] a, input int ex);
    logic [31:0] w;
    int          n;
    w = ad ? {op, a} : {op, 24'h000000};
    n = (ad ? 32 : 8) + ex;
    spi_cs_n = 1'b0;
    #40;
    for (int i = 0; i < n; i++) begin
      serial_in_line = (i < 32) ? w[31 - i] : ~serial_in_line;
      #40 spi_clk = 1'b1;
      #40 spi_clk = 1'b0;
    end
    #40 spi_cs_n = 1'b1;
    serial_in_line = ~serial_in_line;
  endtask
endmodule

// [verification/sfw_sequencer_sva.sv]
// Port assertions for the wipe and sleep sequencer.
`timescale 1ns/1ps
module sfw_sequencer_sva #(
  parameter int WRITE_INHIBIT_CYC = 400,
  parameter int BLOCK_WIPE_CYC    = 200,
  parameter int ARRAY_WIPE_CYC    = 300,
  parameter int SLEEP_ENTRY_CYC   = 10,
  parameter int SLEEP_EXIT_CYC    = 10
) (
  input logic       core_clk,
  input logic       rst_n,
  input logic [2:0] protect_level_bits,
  input logic       cycle_in_progress,
  input logic       write_permit_latch,
  input logic       deep_sleep,
  input logic       standby,
  input logic       write_inhibit,
  input logic       wipe_start,
  input logic       wipe_all,
  input logic [5:0] wipe_sector,
  input logic       wipe_done,
  input logic       lock_bits_clear
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] up_q;
  logic [15:0] busy_q;
  logic [6:0]  lim_q;
  always_ff @(posedge core_clk) begin
    if (!rst_n) up_q <= 16'h0000;
    else if (up_q != 16'hffff) up_q <= up_q + 16'h0001;
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) busy_q <= 16'h0000;
    else if (wipe_start) busy_q <= 16'h0001;
    else if (cycle_in_progress) busy_q <= busy_q + 16'h0001;
  end
  // First sector index that the current protection level covers.
  always_ff @(posedge core_clk) begin
    lim_q <= (protect_level_bits == 3'h0) ? 7'h40 : 7'h40 - (7'h01 << (protect_level_bits - 3'h1));
  end
  property p_reset_state;
    $rose(rst_n) |-> !deep_sleep && !write_permit_latch && !cycle_in_progress && write_inhibit && lock_bits_clear;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("state after reset wrong");
  property p_inhibit_len;
    $fell(write_inhibit) |-> up_q == WRITE_INHIBIT_CYC;
  endproperty
  a_inhibit_len: assert property (p_inhibit_len) else $error("write inhibit span wrong");
  property p_permit_gate;
    $rose(write_permit_latch) |-> !write_inhibit && !deep_sleep && !cycle_in_progress;
  endproperty
  a_permit_gate: assert property (p_permit_gate) else $error("permit set while refused");
  property p_start_state;
    wipe_start |-> cycle_in_progress && !write_permit_latch && $past(write_permit_latch);
  endproperty
  a_start_state: assert property (p_start_state) else $error("wipe start state wrong");
  property p_busy_len;
    wipe_done |-> busy_q == (wipe_all ? ARRAY_WIPE_CYC : BLOCK_WIPE_CYC);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("wipe length wrong");
  property p_done_edge;
    $fell(cycle_in_progress) |-> wipe_done ##1 !wipe_done;
  endproperty
  a_done_edge: assert property (p_done_edge) else $error("wipe done pulse wrong");
  property p_whole_prot;
    wipe_start && wipe_all |-> $past(protect_level_bits) == 3'h0 && wipe_sector == 6'h00;
  endproperty
  a_whole_prot: assert property (p_whole_prot) else $error("whole wipe while protected");
  property p_block_prot;
    wipe_start && !wipe_all |-> {1'b0, wipe_sector} < lim_q;
  endproperty
  a_block_prot: assert property (p_block_prot) else $error("protected sector wiped");
  property p_sleep_quiet;
    deep_sleep |-> !wipe_start && !cycle_in_progress && !standby;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("activity in deep sleep");
endmodule
bind sfw_sequencer sfw_sequencer_sva #(
  .WRITE_INHIBIT_CYC(WRITE_INHIBIT_CYC), .BLOCK_WIPE_CYC(BLOCK_WIPE_CYC), .ARRAY_WIPE_CYC(ARRAY_WIPE_CYC),
  .SLEEP_ENTRY_CYC(SLEEP_ENTRY_CYC), .SLEEP_EXIT_CYC(SLEEP_EXIT_CYC)
) u_sva (
  .core_clk(core_clk), .rst_n(rst_n), .protect_level_bits(protect_level_bits),
  .cycle_in_progress(cycle_in_progress), .write_permit_latch(write_permit_latch), .deep_sleep(deep_sleep),
  .standby(standby), .write_inhibit(write_inhibit), .wipe_start(wipe_start), .wipe_all(wipe_all),
  .wipe_sector(wipe_sector), .wipe_done(wipe_done), .lock_bits_clear(lock_bits_clear)
);

// [verification/tb_top.sv]
// Self-checking bench for the wipe and sleep sequencer.
`timescale 1ns/1ps
module tb_top;
  import sfw_pkg::*;
  localparam int WI = 400;
  localparam int BW = 200;
  localparam int AW = 300;
  localparam int SD = 10;
  logic       core_clk, rst_n, clk_en, spi_clk, spi_cs_n, serial_in_line, all_q;
  logic [2:0] protect_level_bits;
  logic       cycle_in_progress, write_permit_latch, deep_sleep, standby, write_inhibit;
  logic       wipe_start, wipe_all, wipe_done, lock_bits_clear;
  logic [5:0] wipe_sector, sect;
  int         errors, checked, starts, s0, busy_n;
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;
  sfw_sequencer #(.WRITE_INHIBIT_CYC(WI), .BLOCK_WIPE_CYC(BW), .ARRAY_WIPE_CYC(AW),
    .SLEEP_ENTRY_CYC(SD), .SLEEP_EXIT_CYC(SD)) uut (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
    .serial_in_line(serial_in_line), .protect_level_bits(protect_level_bits),
    .cycle_in_progress(cycle_in_progress), .write_permit_latch(write_permit_latch), .deep_sleep(deep_sleep),
    .standby(standby), .write_inhibit(write_inhibit), .wipe_start(wipe_start), .wipe_all(wipe_all),
    .wipe_sector(wipe_sector), .wipe_done(wipe_done), .lock_bits_clear(lock_bits_clear));
  sfw_host_model host (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .serial_in_line(serial_in_line));
  always @(negedge core_clk) begin
    if (wipe_start === 1'b1) begin
      starts++;
      sect = wipe_sector;
      all_q = wipe_all;
      busy_n = 0;
    end
    if (cycle_in_progress === 1'b1) busy_n++;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Select stays high a while after each frame so the sync filter settles.
  task automatic send(input logic [7:0] op, input logic ad, input logic [23:0] a, input int ex);
    host.frame(op, ad, a, ex);
    idle(10);
  endtask
  task automatic finish_wipe(input int n);
    repeat (n + 50) @(negedge core_clk) if (cycle_in_progress !== 1'b1) break;
    check("done", wipe_done, 1);
    check("starts", starts, s0 + 1);
    check("busy_len", busy_n, n);
  endtask
  task automatic t_power();
    idle(10);
    check("permit", write_permit_latch, 0);
    check("lock_clr", lock_bits_clear, 1);
    rst_n = 1'b1;
    idle(3);
    check("standby", standby, 1);
    check("sleep", deep_sleep, 0);
    check("lock_clr", lock_bits_clear, 0);
    send(OP_WRITE_UNLOCK, 1'b0, 24'h000000, 0);
    check("permit", write_permit_latch, 0);
    check("inhibit", write_inhibit, 1);
    repeat (WI) @(negedge core_clk) if (write_inhibit !== 1'b1) break;
    check("inhibit", write_inhibit, 0);
  endtask
  task automatic t_block();
    send(OP_BLOCK_WIPE, 1'b1, 24'h050000, 0);
    check("busy", cycle_in_progress, 0);
    send(OP_WRITE_UNLOCK, 1'b0, 24'h000000, 0);
    check("permit", write_permit_latch, 1);
    send(OP_BLOCK_WIPE, 1'b1, 24'h050000, 4);
    check("busy", cycle_in_progress, 0);
    s0 = starts;
    send(OP_BLOCK_WIPE, 1'b1, 24'hc5abcd, 0);
    check("busy", cycle_in_progress, 1);
    check("permit", write_permit_latch, 0);
    finish_wipe(BW);
    check("sector", sect, 6'h05);
    check("all", all_q, 0);
  endtask
  task automatic t_protect();
    protect_level_bits = 3'h1;
    send(OP_WRITE_UNLOCK, 1'b0, 24'h000000, 0);
    send(OP_BLOCK_WIPE, 1'b1, 24'h3f0000, 0);
    check("busy", cycle_in_progress, 0);
    send(OP_WHOLE_WIPE, 1'b0, 24'h000000, 0);
    check("busy", cycle_in_progress, 0);
    s0 = starts;
    send(OP_BLOCK_WIPE, 1'b1, 24'h3e0000, 0);
    finish_wipe(BW);
    check("sector", sect, 6'h3e);
    protect_level_bits = 3'h0;
    send(OP_WRITE_UNLOCK, 1'b0, 24'h000000, 0);
    send(OP_WHOLE_WIPE, 1'b0, 24'h000000, 1);
    check("busy", cycle_in_progress, 0);
    s0 = starts;
    send(OP_WHOLE_WIPE, 1'b0, 24'h000000, 0);
    check("busy", cycle_in_progress, 1);
    finish_wipe(AW);
    check("all", all_q, 1);
  endtask
  task automatic t_sleep();
    send(OP_WRITE_UNLOCK, 1'b0, 24'h000000, 0);
    s0 = starts;
    send(OP_BLOCK_WIPE, 1'b1, 24'h010000, 0);
    send(OP_SLEEP_ENTRY, 1'b0, 24'h000000, 0);
    finish_wipe(BW);
    idle(SD + 20);
    check("sleep", deep_sleep, 0);
    send(OP_SLEEP_ENTRY, 1'b0, 24'h000000, 0);
    check("sleep", deep_sleep, 0);
    idle(SD);
    check("sleep", deep_sleep, 1);
    check("standby", standby, 0);
    send(OP_WRITE_UNLOCK, 1'b0, 24'h000000, 0);
    check("permit", write_permit_latch, 0);
    send(OP_SLEEP_EXIT, 1'b0, 24'h000000, 3);
    idle(SD + 5);
    check("sleep", deep_sleep, 1);
    send(OP_SLEEP_EXIT, 1'b0, 24'h000000, 0);
    check("sleep", deep_sleep, 1);
    idle(SD + 5);
    check("sleep", deep_sleep, 0);
    check("standby", standby, 1);
  endtask
  // A frozen block must let a whole frame pass unseen and then work on as before.
  task automatic t_freeze();
    clk_en = 1'b0;
    send(OP_WRITE_UNLOCK, 1'b0, 24'h000000, 0);
    check("permit", write_permit_latch, 0);
    clk_en = 1'b1;
    idle(4);
    send(OP_WRITE_UNLOCK, 1'b0, 24'h000000, 0);
    check("permit", write_permit_latch, 1);
  endtask
  initial begin
    errors = 0;
    checked = 0;
    starts = 0;
    s0 = 0;
    busy_n = 0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    protect_level_bits = 3'h0;
    t_power();
    t_block();
    t_protect();
    t_sleep();
    t_freeze();
    stop_test();
  end
  // The full sequence needs roughly 40 us; the limit leaves wide margin.
  initial begin
    #300000;
    errors++;
    stop_test();
  end
endmodule
